//--- rtl/icn_pkg.sv
// Constants, register map and source order of the six-source interrupt controller.
// Assumes byte-wide control registers carried in the low bits of a 32-bit APB word; the status word also uses bits 8 to 13.

`default_nettype none

package icn_pkg;

	localparam int NUM_SRC = 6;

	typedef enum logic [2:0] {
		SRC_PIN0,
		SRC_TIMER0,
		SRC_PIN1,
		SRC_TIMER1,
		SRC_SERIAL,
		SRC_TIMER2
	} icn_src_t;

	// Register byte addresses
	localparam logic [7:0] TMR_CTRL_OFS = 8'h88;
	localparam logic [7:0] IRQ_EN_OFS = 8'ha8;
	localparam logic [7:0] IRQ_PRI_OFS = 8'hb8;
	localparam logic [7:0] STATUS_OFS = 8'hc0;

	// Field positions
	localparam int MASTER_GATE_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int PRI_OFF_BIT = 7;
	localparam int PIN0_TRIG_BIT = 0;
	localparam int PIN0_FLAG_BIT = 1;
	localparam int PIN1_TRIG_BIT = 2;
	localparam int PIN1_FLAG_BIT = 3;
	localparam int ST_LO_BIT = 0;
	localparam int ST_HI_BIT = 1;
	localparam int ST_DEFER_BIT = 2;
	localparam int ST_REQ_LSB = 8;

	// Reset values
	localparam logic [7:0] IRQ_EN_RST = 8'h00;
	localparam logic [7:0] IRQ_PRI_RST = 8'h00;
	localparam logic [1:0] TRIG_RST = 2'h0;

	// Vector layout
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam int VEC_SHIFT = 3;

endpackage : icn_pkg

`default_nettype wire

//--- rtl/icn_timing_if.sv
// Machine-cycle state strobes shared between the controller and its pin detectors.
// Assumes one-cycle pulses on core_clk from the core's state sequencer.

`default_nettype none

interface icn_timing_if;
	logic s3;
	logic s5;
	logic s6;
	modport src (output s3, output s5, output s6);
	modport snk (input s3, input s5, input s6);
endinterface : icn_timing_if

`default_nettype wire

//--- rtl/icn_pin_detect.sv
// Level or falling-edge detector for one external interrupt pin, with its request flag.
// Assumes the pin has already passed a two-stage synchroniser.

`default_nettype none

module icn_pin_detect (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Machine-cycle timing
	icn_timing_if.snk tim,
	// Pin and control
	input wire logic pin_sync,
	input wire logic edge_mode,
	input wire logic hw_clear,
	input wire logic sw_wr,
	input wire logic sw_val,
	// Request flag
	output logic flag_r
);
	logic lat1_r;
	logic lat2_r;
	logic flag_nxt;
	wire set_lvl = !edge_mode && tim.s3 && lat1_r;
	wire set_edge = edge_mode && tim.s3 && lat1_r && !lat2_r;
	wire clr_lvl = !edge_mode && tim.s6;
	wire clr_edge = edge_mode && hw_clear;
	wire clr = clr_lvl || clr_edge || (sw_wr && !sw_val);

	// Set wins over any clear so a request in the clearing cycle survives
	assign flag_nxt = set_lvl || set_edge || (sw_wr && sw_val) || (flag_r && !clr);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lat1_r <= 1'b0;
			lat2_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			if (tim.s5)
				lat1_r <= !pin_sync;
			if (tim.s3)
				lat2_r <= lat1_r;
			flag_r <= flag_nxt;
		end
	end

	a_level_set: assert property (@(posedge core_clk) disable iff (sys_rst)
		set_lvl |=> flag_r) else $error("level request not flagged");
	a_level_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		clr_lvl && !set_lvl && !(sw_wr && sw_val) |=> !flag_r)
		else $error("level flag not cleared at S6");
	a_edge_rearm: assert property (@(posedge core_clk) disable iff (sys_rst)
		edge_mode && tim.s3 && lat2_r && !flag_r && !sw_wr |=> !flag_r)
		else $error("edge flag set without new falling edge");
	a_edge_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		clr_edge && !set_edge && !sw_wr |=> !flag_r)
		else $error("edge flag kept after vector call");

endmodule : icn_pin_detect

`default_nettype wire

//--- rtl/icn_arbiter.sv
// Fixed-order picker: lowest set request index wins.
// Assumes requests are already gated by enables.

`default_nettype none

module icn_arbiter #(
	parameter int N = 6
) (
	// Requests
	input wire logic [N-1:0] req,
	// Grant
	output logic hit,
	output logic [2:0] idx
);
	if (N < 1 || N > 8) begin : g_bad_n
		$error("arbiter width must be 1 to 8");
	end

	always_comb begin
		hit = 1'b0;
		idx = 3'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				hit = 1'b1;
				idx = i[2:0];
			end
		end
	end

endmodule : icn_arbiter

`default_nettype wire

//--- rtl/icn_ctrl_top.sv
// Six-source interrupt controller: APB registers, pin detection, two-level arbitration
// and vector call towards the core.
// Assumes the core supplies S3/S5/S6 strobes, an instruction-done pulse and a return pulse.

`default_nettype none

module icn_ctrl_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core timing and sequencing
	input wire logic state_s3,
	input wire logic state_s5,
	input wire logic state_s6,
	input wire logic instr_done,
	input wire logic return_from_service,
	// Request sources
	input wire logic ext_pin_zero,
	input wire logic ext_pin_one,
	input wire logic timer0_source,
	input wire logic timer1_source,
	input wire logic serial_source,
	input wire logic timer2_source,
	// Vector call
	output logic vector_call,
	output logic [15:0] vector_addr,
	output logic [2:0] vector_source
);
	localparam int NS = icn_pkg::NUM_SRC;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] pin_meta_r;
	logic [1:0] pin_sync_r;

	// Pins idle high, so the chain resets high to avoid a false edge
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_r <= 2'h3;
			pin_sync_r <= 2'h3;
		end else begin
			pin_meta_r <= {ext_pin_one, ext_pin_zero};
			pin_sync_r <= pin_meta_r;
		end
	end

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic [7:0] irq_en_r;
	logic [7:0] irq_pri_r;
	logic [1:0] trig_r;
	logic in_lo_r;
	logic in_hi_r;
	logic defer_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	wire setup = psel && !penable;
	wire access = psel && penable;
	wire wr_en = access && pwrite;
	wire sel_tmr = paddr == icn_pkg::TMR_CTRL_OFS;
	wire sel_en = paddr == icn_pkg::IRQ_EN_OFS;
	wire sel_pri = paddr == icn_pkg::IRQ_PRI_OFS;
	wire sel_st = paddr == icn_pkg::STATUS_OFS;
	wire mapped = sel_tmr || sel_en || sel_pri || (sel_st && !pwrite);
	wire wr_tmr = wr_en && sel_tmr;
	wire wr_en_reg = wr_en && sel_en;
	wire wr_pri_reg = wr_en && sel_pri;
	wire wr_ctrl = wr_en_reg || wr_pri_reg;

	// Zero-wait slave: data is staged in the setup cycle
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = access && pslverr_r;

	// ****************************************************************
	// Pin detectors
	// ****************************************************************
	icn_timing_if tim ();
	assign tim.s3 = state_s3;
	assign tim.s5 = state_s5;
	assign tim.s6 = state_s6;

	logic pin0_request_flag;
	logic pin1_request_flag;
	logic take;
	logic [2:0] take_idx;

	wire pin0_trigger_select = trig_r[0];
	wire pin1_trigger_select = trig_r[1];
	wire clr_pin0 = take && take_idx == icn_pkg::SRC_PIN0;
	wire clr_pin1 = take && take_idx == icn_pkg::SRC_PIN1;

	icn_pin_detect u_pin0 (
		.core_clk (core_clk),
		.sys_rst (sys_rst),
		.tim (tim),
		.pin_sync (pin_sync_r[0]),
		.edge_mode (pin0_trigger_select),
		.hw_clear (clr_pin0),
		.sw_wr (wr_tmr),
		.sw_val (pwdata[icn_pkg::PIN0_FLAG_BIT]),
		.flag_r (pin0_request_flag)
	);

	icn_pin_detect u_pin1 (
		.core_clk (core_clk),
		.sys_rst (sys_rst),
		.tim (tim),
		.pin_sync (pin_sync_r[1]),
		.edge_mode (pin1_trigger_select),
		.hw_clear (clr_pin1),
		.sw_wr (wr_tmr),
		.sw_val (pwdata[icn_pkg::PIN1_FLAG_BIT]),
		.flag_r (pin1_request_flag)
	);

	// ****************************************************************
	// Gating and arbitration
	// ****************************************************************
	wire [NS-1:0] raw_req = {timer2_source, serial_source, timer1_source,
		pin1_request_flag, timer0_source, pin0_request_flag};
	wire master_irq_gate = irq_en_r[icn_pkg::MASTER_GATE_BIT];
	wire [NS-1:0] act_req = raw_req & irq_en_r[NS-1:0] & {NS{master_irq_gate}};
	wire [NS-1:0] hi_lvl = irq_pri_r[NS-1:0];
	wire pri_on = !irq_pri_r[icn_pkg::PRI_OFF_BIT];
	// Uniform priority bits collapse to one level
	wire mixed = (|hi_lvl) && !(&hi_lvl);
	wire [NS-1:0] hi_req = act_req & (mixed ? hi_lvl : {NS{1'b0}});

	logic hi_hit;
	logic [2:0] hi_idx;
	logic any_hit;
	logic [2:0] any_idx;

	icn_arbiter #(.N(NS)) u_arb_hi (
		.req (hi_req),
		.hit (hi_hit),
		.idx (hi_idx)
	);

	icn_arbiter #(.N(NS)) u_arb_any (
		.req (act_req),
		.hit (any_hit),
		.idx (any_idx)
	);

	// Idle: high level first; low in service: only high may preempt
	wire idle = !in_lo_r && !in_hi_r;
	wire grant_on = !pri_on ? any_hit :
		in_hi_r ? 1'b0 :
		idle ? any_hit : hi_hit;
	wire grant_hi = pri_on && hi_hit;
	wire [2:0] grant_idx = grant_hi ? hi_idx : any_idx;

	// Returns and enable or priority writes hold the call back one instruction
	wire defer_hit = defer_r || wr_ctrl || return_from_service;
	assign take = instr_done && !defer_hit && grant_on;
	assign take_idx = grant_idx;

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_en_r <= icn_pkg::IRQ_EN_RST;
			irq_pri_r <= icn_pkg::IRQ_PRI_RST;
			trig_r <= icn_pkg::TRIG_RST;
		end else begin
			if (wr_en_reg)
				irq_en_r <= pwdata[7:0];
			if (wr_pri_reg)
				irq_pri_r <= pwdata[7:0];
			if (wr_tmr)
				trig_r <= {pwdata[icn_pkg::PIN1_TRIG_BIT], pwdata[icn_pkg::PIN0_TRIG_BIT]};
		end
	end

	// An event blocks only the end of its own instruction; the following end may call
	wire defer_nxt = !instr_done && defer_hit;

	// Level tracking; without the priority circuit only one mark is kept
	wire hi_mark = take && grant_hi;
	wire lo_mark = take && !grant_hi;
	wire hi_ret = return_from_service && in_hi_r;
	wire lo_ret = return_from_service && !in_hi_r;
	wire in_hi_nxt = hi_mark || (in_hi_r && !hi_ret);
	wire in_lo_nxt = lo_mark || (in_lo_r && !lo_ret);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			defer_r <= 1'b0;
			in_hi_r <= 1'b0;
			in_lo_r <= 1'b0;
		end else begin
			defer_r <= defer_nxt;
			in_hi_r <= in_hi_nxt;
			in_lo_r <= in_lo_nxt;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [7:0] rd_tmr;
	logic [31:0] rd_st;
	logic [31:0] rd_word;

	always_comb begin
		rd_tmr = 8'h00;
		rd_tmr[icn_pkg::PIN0_TRIG_BIT] = trig_r[0];
		rd_tmr[icn_pkg::PIN0_FLAG_BIT] = pin0_request_flag;
		rd_tmr[icn_pkg::PIN1_TRIG_BIT] = trig_r[1];
		rd_tmr[icn_pkg::PIN1_FLAG_BIT] = pin1_request_flag;
		rd_st = 32'h0;
		rd_st[icn_pkg::ST_LO_BIT] = in_lo_r;
		rd_st[icn_pkg::ST_HI_BIT] = in_hi_r;
		rd_st[icn_pkg::ST_DEFER_BIT] = defer_r;
		rd_st[icn_pkg::ST_REQ_LSB +: NS] = raw_req;
	end

	wire [7:0] rd_en = irq_en_r | (8'h1 << icn_pkg::RSVD_BIT);
	wire [7:0] rd_pri = irq_pri_r | (8'h1 << icn_pkg::RSVD_BIT);

	assign rd_word = sel_tmr ? {24'h0, rd_tmr} :
		sel_en ? {24'h0, rd_en} :
		sel_pri ? {24'h0, rd_pri} :
		sel_st ? rd_st : 32'h0;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= pwrite ? 32'h0 : rd_word;
			pslverr_r <= !mapped;
		end
	end

	// ****************************************************************
	// Vector call
	// ****************************************************************
	wire [15:0] vec_nxt = icn_pkg::VEC_BASE + {10'h0, grant_idx, 3'h0};

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			vector_call <= 1'b0;
			vector_addr <= 16'h0;
			vector_source <= 3'h0;
		end else begin
			vector_call <= take;
			if (take) begin
				vector_addr <= vec_nxt;
				vector_source <= grant_idx;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	a_vector_map: assert property (vector_call |->
		vector_addr == icn_pkg::VEC_BASE + {10'h0, vector_source, 3'h0})
		else $error("vector address does not match source");
	a_src_enable: assert property (vector_call |->
		$past(irq_en_r[grant_idx] && raw_req[grant_idx]))
		else $error("call for disabled or idle source");
	a_master_gate: assert property (vector_call |-> $past(master_irq_gate))
		else $error("call with master gate closed");
	a_rsvd_read: assert property (setup && !pwrite && (sel_en || sel_pri) |=>
		prdata[icn_pkg::RSVD_BIT]) else $error("reserved bit read as zero");
	a_preempt_lo: assert property (pri_on && in_lo_r && !in_hi_r && hi_hit &&
		instr_done && !defer_hit |=> vector_call && in_hi_r)
		else $error("high request did not preempt");
	a_hi_blocks: assert property (pri_on && in_hi_r |=> !vector_call)
		else $error("call during high-level routine");
	a_pri_off: assert property (!pri_on && any_hit && instr_done && !defer_hit |=>
		vector_call) else $error("enabled request refused with priority off");
	a_fixed_order: assert property (take && !grant_hi |->
		(act_req & ((6'h1 << grant_idx) - 6'h1)) == 6'h0)
		else $error("fixed order violated");
	a_one_level: assert property (pri_on && !mixed && in_lo_r |=> !vector_call)
		else $error("preemption with uniform priority");
	a_call_timing: assert property (vector_call |-> $past(instr_done))
		else $error("call outside instruction end");
	a_defer_call: assert property (instr_done && defer_hit |=> !vector_call)
		else $error("call not deferred");
	a_defer_hold: assert property (!instr_done && (wr_ctrl || return_from_service) |=>
		defer_r) else $error("deferral not held to instruction end");
	a_level_track: assert property (return_from_service && !take |=>
		!($past(in_hi_r) ? in_hi_r : in_lo_r)) else $error("level not released");

	c_preempt: cover property (in_lo_r ##1 vector_call && in_hi_r);
	c_deferred: cover property (instr_done && defer_r && grant_on ##1 !vector_call);
	c_nest_off: cover property (!pri_on && in_lo_r && take);

endmodule : icn_ctrl_top

`default_nettype wire

//--- verif/icn_core_model.sv
// Behavioural core sequencer: S3/S5/S6 strobes, instruction ends and returns.
// Assumes six core_clk cycles to a machine cycle and one machine cycle to an instruction.

`default_nettype none

module icn_core_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Bench command
	input wire logic ret_req,
	// Sequencer outputs
	output logic state_s3,
	output logic state_s5,
	output logic state_s6,
	output logic instr_done,
	output logic return_from_service
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] phase_r;
	logic ret_pend_r;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_r <= 3'h0;
			ret_pend_r <= 1'b0;
		end else begin
			phase_r <= (phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
			// A request never gets lost when it lands on the return cycle
			if (ret_req)
				ret_pend_r <= 1'b1;
			else if (phase_r == 3'h5)
				ret_pend_r <= 1'b0;
		end
	end

	assign state_s3 = !sys_rst && phase_r == 3'h2;
	assign state_s5 = !sys_rst && phase_r == 3'h4;
	assign state_s6 = !sys_rst && phase_r == 3'h5;
	assign instr_done = state_s6;
	assign return_from_service = instr_done && ret_pend_r;
endmodule // icn_core_model

`default_nettype wire

//--- verif/six_source_interrupt_controller_tb.sv
// Self-checking bench for the six-source interrupt controller.
// Assumes the core model supplies machine-cycle timing; pins are active low.

`default_nettype none

module six_source_interrupt_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic s3, s5, s6, idone, rfs, ret_req, e, got, wdone;
	logic pin0, pin1, t0, t1, ser, t2, vcall;
	logic [15:0] vaddr, caddr;
	logic [2:0] vsrc, csrc;
	logic [5:0] m;
	int fails, checked, seed, ndone;

	icn_ctrl_top i_icn_ctrl_top (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .state_s3(s3), .state_s5(s5), .state_s6(s6),
		.instr_done(idone), .return_from_service(rfs), .ext_pin_zero(pin0),
		.ext_pin_one(pin1), .timer0_source(t0), .timer1_source(t1), .serial_source(ser),
		.timer2_source(t2), .vector_call(vcall), .vector_addr(vaddr), .vector_source(vsrc));

	icn_core_model i_icn_core_model (.core_clk(core_clk), .sys_rst(sys_rst),
		.ret_req(ret_req), .state_s3(s3), .state_s5(s5), .state_s6(s6),
		.instr_done(idone), .return_from_service(rfs));

	always #5 core_clk = ~core_clk;

	// ****************************************
	// Bench tasks
	// ****************************************
	function automatic logic [15:0] exp_addr(input logic [2:0] s);
		return 16'h0003 + {10'h000, s, 3'h0};
	endfunction

	function automatic logic [2:0] first_src(input logic [5:0] r);
		for (int i = 5; i >= 0; i--)
			if (r[i])
				first_src = 3'(i);
	endfunction

	task chk(input logic [31:0] a, input logic [31:0] b, input string msg);
		checked++;
		if (a !== b) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, a, b);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		wdone = idone;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pins are active low, the other sources active high
	task set_src(input logic [5:0] r);
		pin0 <= ~r[0];
		t0 <= r[1];
		pin1 <= ~r[2];
		t1 <= r[3];
		ser <= r[4];
		t2 <= r[5];
	endtask

	task wait_call(input int n);
		got = 1'b0;
		ndone = 0;
		for (int i = 0; i < n && !got; i++) begin
			@(posedge core_clk);
			if (idone === 1'b1)
				ndone++;
			if (vcall === 1'b1) begin
				got = 1'b1;
				csrc = vsrc;
				caddr = vaddr;
			end
		end
	endtask

	task serve(input logic [5:0] r, input logic [2:0] s);
		@(posedge core_clk);
		set_src(r);
		wait_call(80);
		chk({31'h0, got}, 32'h1, "call missing");
		chk({29'h0, csrc}, {29'h0, s}, "source");
		chk({16'h0, caddr}, {16'h0, exp_addr(s)}, "vector");
		set_src(6'h00);
	endtask

	task quiet(input logic [5:0] r);
		@(posedge core_clk);
		set_src(r);
		wait_call(80);
		chk({31'h0, got}, 32'h0, "unexpected call");
		set_src(6'h00);
	endtask

	task ret();
		@(posedge core_clk);
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		repeat (12) @(posedge core_clk);
	endtask

	task tend(input string name);
		$display("test %s done", name);
	endtask

	task results();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		results();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, ret_req} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{pin0, pin1, t0, t1, ser, t2} = 6'h30;
		seed = 32'h0879;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		apb(1'b0, 8'ha8, 32'h0);
		chk(q, 32'h40, "enable reset");
		apb(1'b0, 8'hb8, 32'h0);
		chk(q, 32'h40, "priority reset");
		apb(1'b1, 8'ha8, 32'h3f);
		apb(1'b0, 8'ha8, 32'h0);
		chk(q, 32'h7f, "enable readback");
		apb(1'b1, 8'hc0, 32'h0);
		chk({31'h0, e}, 32'h1, "status write error");
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		tend("registers");
		quiet(6'h02);
		apb(1'b1, 8'ha8, 32'hbd);
		quiet(6'h02);
		tend("gates");
		apb(1'b1, 8'ha8, 32'hbf);
		for (int s = 0; s < 6; s++) begin
			serve(6'(1 << s), 3'(s));
			if (s != 0 && s != 2)
				chk(ndone, 32'h1, "call latency");
			apb(1'b0, 8'hc0, 32'h0);
			chk({30'h0, q[1:0]}, 32'h1, "low in service");
			ret();
			apb(1'b0, 8'hc0, 32'h0);
			chk({30'h0, q[1:0]}, 32'h0, "service cleared");
		end
		tend("vectors");
		// A pending request opened by an enable write waits one more instruction
		apb(1'b1, 8'ha8, 32'h3f);
		set_src(6'h02);
		apb(1'b1, 8'ha8, 32'hbf);
		wait_call(40);
		chk({31'h0, got}, 32'h1, "deferred call missing");
		chk(ndone, wdone ? 32'h1 : 32'h2, "deferred call timing");
		set_src(6'h00);
		ret();
		tend("deferral");
		serve(6'h3a, 3'h1);
		ret();
		repeat (8) begin
			m = 6'($random(seed)) & 6'h3a;
			if (m == 6'h00)
				m = 6'h30;
			serve(m, first_src(m));
			ret();
		end
		tend("fixed order");
		apb(1'b1, 8'hb8, 32'h30);
		serve(6'h22, 3'h5);
		ret();
		serve(6'h02, 3'h1);
		serve(6'h10, 3'h4);
		apb(1'b0, 8'hc0, 32'h0);
		chk({30'h0, q[1:0]}, 32'h3, "both in service");
		quiet(6'h20);
		ret();
		ret();
		tend("preemption");
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, 8'hb8, p ? 32'h3f : 32'h00);
			serve(6'h20, 3'h5);
			quiet(6'h02);
			ret();
		end
		apb(1'b1, 8'hb8, 32'h80);
		serve(6'h20, 3'h5);
		serve(6'h02, 3'h1);
		ret();
		ret();
		tend("levels");
		apb(1'b1, 8'hb8, 32'h00);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 8'h88, k ? 32'h04 : 32'h01);
			apb(1'b0, 8'h88, 32'h0);
			chk(q, k ? 32'h04 : 32'h01, "trigger readback");
			set_src(k ? 6'h04 : 6'h01);
			wait_call(80);
			chk({31'h0, got}, 32'h1, "edge call");
			chk({29'h0, csrc}, k ? 32'h2 : 32'h0, "edge source");
			ret();
			// Pin stays low: a single edge must be served once only
			wait_call(80);
			chk({31'h0, got}, 32'h0, "edge served twice");
			set_src(6'h00);
			// Let the released pin reach the latch before its mode changes
			repeat (12) @(posedge core_clk);
		end
		tend("edge mode");
		results();
	end
endmodule // six_source_interrupt_controller_tb

`default_nettype wire
